// ### include/spu_cfg.svh
// Purpose: Offsets, field positions and reset values of the serial port
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: Included by the serial port design, assertions and bench
`ifndef SPU_CFG_SVH
`define SPU_CFG_SVH
// Register byte offsets
`define SPU_OFF_STOP     8'h00
`define SPU_OFF_CTRL     8'h04
`define SPU_OFF_STATUS   8'h08
`define SPU_OFF_TXHOLD   8'h0c
`define SPU_OFF_RXHOLD   8'h10
`define SPU_OFF_PORT     8'h14
`define SPU_OFF_BAUD     8'h18
// Control fields
`define SPU_CTRL_TE      0
`define SPU_CTRL_RE      1
`define SPU_CTRL_TIE     2
`define SPU_CTRL_TX_END_IRQ_ENABLE    3
`define SPU_CTRL_SYNC    4
`define SPU_CTRL_PAREN   5
// Status fields
`define SPU_ST_TX_BUFFER_EMPTY_FLAG      7
`define SPU_ST_RDRF      6
`define SPU_ST_OVERRUN_ERROR_FLAG      5
`define SPU_ST_FER       4
`define SPU_ST_PER       3
`define SPU_ST_TEND      2
`define SPU_ST_RER       1
// Port register fields
`define SPU_PORT_DATA    0
`define SPU_PORT_DIR     1
// Reset values
`define SPU_STOP_RST     1'b1
`define SPU_STATUS_RST   8'h84
`define SPU_BAUD_RST     16'h0363
`endif

// ### include/spu_pkg.sv
// Purpose: Types shared by the serial port design
// Assumes: spu_cfg.svh holds all numbers
// Notes: Types only
package spu_pkg;
	typedef enum logic [1:0] {
		SPU_IDLE  = 2'b00,
		SPU_START = 2'b01,
		SPU_DATA  = 2'b10,
		SPU_STOP  = 2'b11
	} spu_state_t;
endpackage

// ### rtl/spu_serial_port.sv
// Purpose: Serial port (async and clocked sync) with AHB-Lite register slave
// Assumes: Single 32-bit transfers, zero wait states, OKAY response only
// Notes: 8 data bits, optional even parity, one stop bit in async mode
//
// Summary of operation
// - After reset the block is stopped; registers other than stop control are inaccessible.
// - A break sets the framing error flag and possibly the parity error flag.
// - Reception continues after a break, so framing error sets again.
// - With transmit enable clear the output pin follows port direction and data.
// - Clearing transmit enable resets the transmitter at once and hands pin to port.
// - In sync mode transmission waits while overrun, framing or sync error is set.
// - Clearing receive enable leaves receive error flags untouched.
// - Moving holding register into shift register sets the buffer empty flag.
// - Holding register writes always land, overwriting an untransferred value.
// - Stopping resets transmit shift, holding and status; pin then follows port direction and data.
// - Stopping resets receive shift, holding and status; frame in flight invalid.
`timescale 1ns/10ps
`include "spu_cfg.svh"
module spu_serial_port
	import spu_pkg::*;
#(
	parameter int BAUD_W = 16
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Serial pins
	input  wire logic        rxd_in,
	input  wire logic        sck_in,
	output logic             txd_out,
	output logic             txd_oe,
	// Requests to the DMA controller
	output logic             tx_empty_request,
	output logic             rx_full_request
);
	// Bus address-phase capture
	logic        wr_pend_reg;
	logic        rd_pend_reg;
	logic [7:0]  addr_reg;
	// Registers
	logic        module_stop_reg;
	logic        transmit_enable, receive_enable, tx_empty_irq_enable, tx_end_irq_enable;
	logic        sync_mode_reg, parity_en_reg;
	logic [7:0]  tx_holding_register;
	logic [7:0]  rx_holding_register;
	logic        tx_buffer_empty_flag, rx_full_flag, overrun_error_flag;
	logic        framing_error_flag, parity_error_flag, tx_end_flag, sync_receive_error_flag;
	logic        port_data_register, port_dir_reg;
	logic [BAUD_W-1:0] baud_reg;
	// Transmitter
	spu_state_t  tx_state_reg;
	logic [7:0]  tx_shift_register;
	logic [3:0]  tx_bit_reg;
	logic        tx_par_reg, tx_line_reg;
	logic [BAUD_W-1:0] tx_cnt_reg;
	// Receiver
	spu_state_t  rx_state_reg;
	logic [7:0]  rx_shift_register;
	logic [3:0]  rx_bit_reg;
	logic        rx_par_reg;
	logic [BAUD_W-1:0] rx_cnt_reg;
	// Synchronisers
	logic        rxd_meta, rxd_sync, sck_meta, sck_sync, sck_prev;

	logic        wr_en, rd_en, sel_valid;
	logic        wr_ctrl, wr_status, wr_tx, rd_rx, rd_status_any;
	logic        tx_load, rx_done, rx_bad_frame, rx_bad_par;
	logic        sck_rise, sck_fall, tx_tick, rx_tick, rx_half;
	logic        rx_err_block, stopped, te_off;
	logic [31:0] status_word;

	// Pin inputs pass two flip-flops before use
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
			sck_meta <= 1'b1;
			sck_sync <= 1'b1;
			sck_prev <= 1'b1;
		end else begin
			rxd_meta <= rxd_in;
			rxd_sync <= rxd_meta;
			sck_meta <= sck_in;
			sck_sync <= sck_meta;
			sck_prev <= sck_sync;
		end
	end
	assign sck_fall = sck_prev & ~sck_sync;
	assign sck_rise = ~sck_prev & sck_sync;

	// Address phase capture; zero wait states so hreadyout stays high
	assign sel_valid = hsel & hready & htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
		end else begin
			wr_pend_reg <= sel_valid & hwrite;
			rd_pend_reg <= sel_valid & ~hwrite;
			addr_reg    <= haddr[7:0];
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Only stop control answers while stopped
	assign stopped   = module_stop_reg;
	assign wr_en     = wr_pend_reg & ~stopped;
	assign rd_en     = rd_pend_reg & ~stopped;
	assign wr_ctrl   = wr_en & (addr_reg == `SPU_OFF_CTRL);
	assign wr_status = wr_en & (addr_reg == `SPU_OFF_STATUS);
	assign wr_tx     = wr_en & (addr_reg == `SPU_OFF_TXHOLD);
	assign rd_rx     = rd_en & (addr_reg == `SPU_OFF_RXHOLD);
	assign rd_status_any = rd_en & (addr_reg == `SPU_OFF_STATUS);
	assign te_off    = ~transmit_enable;

	// Module stop control
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			module_stop_reg <= `SPU_STOP_RST;
		else if (wr_pend_reg && addr_reg == `SPU_OFF_STOP)
			module_stop_reg <= hwdata[0];
	end

	// Control, port and baud registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			transmit_enable     <= 1'b0;
			receive_enable      <= 1'b0;
			tx_empty_irq_enable <= 1'b0;
			tx_end_irq_enable   <= 1'b0;
			sync_mode_reg       <= 1'b0;
			parity_en_reg       <= 1'b0;
			port_data_register  <= 1'b0;
			port_dir_reg        <= 1'b0;
			baud_reg            <= BAUD_W'(`SPU_BAUD_RST);
		end else begin
			if (wr_ctrl) begin
				transmit_enable     <= hwdata[`SPU_CTRL_TE];
				receive_enable      <= hwdata[`SPU_CTRL_RE];
				tx_empty_irq_enable <= hwdata[`SPU_CTRL_TIE];
				tx_end_irq_enable   <= hwdata[`SPU_CTRL_TX_END_IRQ_ENABLE];
				sync_mode_reg       <= hwdata[`SPU_CTRL_SYNC];
				parity_en_reg       <= hwdata[`SPU_CTRL_PAREN];
			end
			if (wr_en && addr_reg == `SPU_OFF_PORT) begin
				port_data_register <= hwdata[`SPU_PORT_DATA];
				port_dir_reg       <= hwdata[`SPU_PORT_DIR];
			end
			if (wr_en && addr_reg == `SPU_OFF_BAUD)
				baud_reg <= hwdata[BAUD_W-1:0];
		end
	end

	// Holding register takes every write, old untransferred data is lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tx_holding_register <= 8'h00;
		else if (stopped)
			tx_holding_register <= 8'h00;
		else if (wr_tx)
			tx_holding_register <= hwdata[7:0];
	end

	// Bit timing: baud divider in async mode, external clock edges in sync mode
	assign tx_tick = sync_mode_reg ? sck_fall : (tx_cnt_reg == '0);
	assign rx_tick = sync_mode_reg ? sck_rise : (rx_cnt_reg == '0);
	assign rx_half = rx_cnt_reg == (baud_reg >> 1);
	// Receive errors stall sync transmission until software clears them
	assign rx_err_block = sync_mode_reg &
		(overrun_error_flag | framing_error_flag | sync_receive_error_flag);
	assign tx_load = (tx_state_reg == SPU_IDLE) & ~tx_buffer_empty_flag & ~rx_err_block & transmit_enable;

	// Transmitter; clearing enable abandons any frame at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state_reg      <= SPU_IDLE;
			tx_shift_register <= 8'h00;
			tx_bit_reg        <= 4'h0;
			tx_par_reg        <= 1'b0;
			tx_line_reg       <= 1'b1;
			tx_cnt_reg        <= '0;
		end else if (te_off || stopped) begin
			tx_state_reg      <= SPU_IDLE;
			tx_shift_register <= 8'h00;
			tx_bit_reg        <= 4'h0;
			tx_line_reg       <= 1'b1;
			tx_cnt_reg        <= '0;
		end else begin
			tx_cnt_reg <= (tx_cnt_reg == '0) ? baud_reg : tx_cnt_reg - 1'b1;
			unique case (tx_state_reg)
				SPU_IDLE: begin
					if (tx_load) begin
						tx_shift_register <= tx_holding_register;
						tx_par_reg        <= 1'b0;
						tx_bit_reg        <= sync_mode_reg ? 4'hf : 4'h0; // Sync first fall only shows bit 0
						tx_cnt_reg        <= baud_reg;
						tx_state_reg      <= sync_mode_reg ? SPU_DATA : SPU_START;
						tx_line_reg       <= sync_mode_reg ? tx_line_reg : 1'b0;
					end
				end
				SPU_START: begin
					if (tx_tick) begin
						tx_line_reg  <= tx_shift_register[0];
						tx_state_reg <= SPU_DATA;
					end
				end
				SPU_DATA: begin
					if (sync_mode_reg && tx_tick && tx_bit_reg == 4'hf)
						tx_line_reg <= tx_shift_register[0];
					else if (tx_tick) begin
						tx_par_reg        <= tx_par_reg ^ tx_shift_register[0];
						tx_shift_register <= {1'b0, tx_shift_register[7:1]};
						tx_line_reg       <= tx_shift_register[1];
						if (tx_bit_reg == 4'h7 && !parity_en_reg) begin
							tx_line_reg  <= 1'b1;
							tx_state_reg <= sync_mode_reg ? SPU_IDLE : SPU_STOP;
						end else if (tx_bit_reg == 4'h7) begin
							tx_line_reg <= tx_par_reg ^ tx_shift_register[0];
						end else if (tx_bit_reg == 4'h8) begin
							tx_line_reg  <= 1'b1;
							tx_state_reg <= SPU_STOP;
						end
					end
					// Sync pre-count wraps to 0 so all eight data bits leave before idle
					if (tx_tick)
						tx_bit_reg <= tx_bit_reg + 4'h1;
				end
				SPU_STOP: begin
					if (tx_tick)
						tx_state_reg <= SPU_IDLE;
				end
			endcase
		end
	end

	// Receiver keeps running through a break so framing errors repeat
	assign rx_bad_frame = ~sync_mode_reg & ~rxd_sync;
	assign rx_bad_par   = parity_en_reg & (rx_par_reg != rxd_sync);
	assign rx_done      = (rx_state_reg == SPU_STOP) & (sync_mode_reg ? 1'b1 : rx_tick);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state_reg      <= SPU_IDLE;
			rx_shift_register <= 8'h00;
			rx_bit_reg        <= 4'h0;
			rx_par_reg        <= 1'b0;
			rx_cnt_reg        <= '0;
		end else if (!receive_enable || stopped) begin
			rx_state_reg      <= SPU_IDLE;
			rx_shift_register <= 8'h00;
			rx_bit_reg        <= 4'h0;
			rx_cnt_reg        <= '0;
		end else begin
			rx_cnt_reg <= (rx_cnt_reg == '0) ? baud_reg : rx_cnt_reg - 1'b1;
			unique case (rx_state_reg)
				SPU_IDLE: begin
					rx_bit_reg <= 4'h0;
					rx_par_reg <= 1'b0;
					if (sync_mode_reg && sck_rise) begin
						rx_shift_register <= {rxd_sync, rx_shift_register[7:1]};
						rx_bit_reg        <= 4'h1;
						rx_state_reg      <= SPU_DATA;
					end else if (!sync_mode_reg && !rxd_sync) begin
						rx_cnt_reg   <= baud_reg;
						rx_state_reg <= SPU_START;
					end
				end
				SPU_START: begin
					if (rx_half)
						rx_cnt_reg <= baud_reg;
					if (rx_half)
						rx_state_reg <= SPU_DATA;
				end
				SPU_DATA: begin
					if (rx_tick) begin
						rx_bit_reg <= rx_bit_reg + 4'h1;
						if (rx_bit_reg < 4'h8) begin
							rx_shift_register <= {rxd_sync, rx_shift_register[7:1]};
							rx_par_reg        <= rx_par_reg ^ rxd_sync;
						end
						if ((rx_bit_reg == 4'h7 && !parity_en_reg) || rx_bit_reg == 4'h8)
							rx_state_reg <= SPU_STOP;
					end
				end
				SPU_STOP: begin
					if (rx_done)
						rx_state_reg <= SPU_IDLE;
				end
			endcase
		end
	end

	// Status flags; hardware set wins over software clear, write 0 clears
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{tx_buffer_empty_flag, rx_full_flag, overrun_error_flag, framing_error_flag,
			 parity_error_flag, tx_end_flag, sync_receive_error_flag} <= 7'h42;
			rx_holding_register <= 8'h00;
		end else if (stopped) begin
			tx_buffer_empty_flag    <= 1'b1;
			tx_end_flag             <= 1'b1;
			rx_full_flag            <= 1'b0;
			overrun_error_flag      <= 1'b0;
			framing_error_flag      <= 1'b0;
			parity_error_flag       <= 1'b0;
			sync_receive_error_flag <= 1'b0;
			rx_holding_register     <= 8'h00;
		end else begin
			// Error flags are cleared here and by stopping, never by receive enable
			if (wr_status) begin
				if (!hwdata[`SPU_ST_TX_BUFFER_EMPTY_FLAG]) tx_buffer_empty_flag    <= 1'b0;
				if (!hwdata[`SPU_ST_RDRF]) rx_full_flag            <= 1'b0;
				if (!hwdata[`SPU_ST_OVERRUN_ERROR_FLAG]) overrun_error_flag      <= 1'b0;
				if (!hwdata[`SPU_ST_FER])  framing_error_flag      <= 1'b0;
				if (!hwdata[`SPU_ST_PER])  parity_error_flag       <= 1'b0;
				if (!hwdata[`SPU_ST_TEND]) tx_end_flag             <= 1'b0;
				if (!hwdata[`SPU_ST_RER])  sync_receive_error_flag <= 1'b0;
			end
			if (rd_rx)
				rx_full_flag <= 1'b0;
			if (tx_load) begin
				tx_buffer_empty_flag <= 1'b1;
				tx_end_flag          <= 1'b0;
			end
			if (tx_state_reg != SPU_IDLE && te_off)
				tx_end_flag <= 1'b1;
			if (rx_done) begin
				if (rx_full_flag) begin
					overrun_error_flag      <= 1'b1;
					sync_receive_error_flag <= sync_mode_reg;
				end else if (rx_bad_frame)
					framing_error_flag <= 1'b1;
				else begin
					rx_holding_register <= rx_shift_register;
					if (rx_bad_par && !sync_mode_reg)
						parity_error_flag <= 1'b1;
					else
						rx_full_flag <= 1'b1;
				end
				if (rx_bad_frame && rx_bad_par)
					parity_error_flag <= 1'b1;
			end
		end
	end

	// Pin: shifter while enabled, port registers otherwise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txd_out <= 1'b1;
			txd_oe  <= 1'b0;
		end else if (transmit_enable && !stopped) begin
			txd_out <= tx_line_reg;
			txd_oe  <= 1'b1;
		end else begin
			txd_out <= port_data_register;
			txd_oe  <= port_dir_reg;
		end
	end

	// DMA requests; receive full is the only source for receive reads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_empty_request <= 1'b0;
			rx_full_request  <= 1'b0;
		end else begin
			tx_empty_request <= tx_buffer_empty_flag & tx_empty_irq_enable & transmit_enable & ~stopped;
			rx_full_request  <= rx_full_flag & receive_enable & ~stopped;
		end
	end

	// Read data
	assign status_word = {24'h0, tx_buffer_empty_flag, rx_full_flag, overrun_error_flag,
		framing_error_flag, parity_error_flag, tx_end_flag, sync_receive_error_flag, 1'b0};
	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_pend_reg && addr_reg == `SPU_OFF_STOP)
			hrdata = {31'h0, module_stop_reg};
		else if (rd_en) begin
			unique case (addr_reg)
				`SPU_OFF_CTRL:   hrdata = {26'h0, parity_en_reg, sync_mode_reg, tx_end_irq_enable,
					tx_empty_irq_enable, receive_enable, transmit_enable};
				`SPU_OFF_STATUS: hrdata = status_word;
				`SPU_OFF_TXHOLD: hrdata = {24'h0, tx_holding_register};
				`SPU_OFF_RXHOLD: hrdata = {24'h0, rx_holding_register};
				`SPU_OFF_PORT:   hrdata = {30'h0, port_dir_reg, port_data_register};
				`SPU_OFF_BAUD:   hrdata = 32'(baud_reg);
				default:         hrdata = 32'h0000_0000;
			endcase
		end
	end
endmodule

// ### bench/spu_serial_port_sva.sv
// Purpose: Port-level checks of the serial port
// Assumes: Stop, control and port words are shadowed from bus writes
// Notes: Shadows update on the same edge as the block's own registers
`timescale 1ns/10ps
`include "spu_cfg.svh"
module spu_sva (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Pins and requests
	input wire logic        txd_out,
	input wire logic        txd_oe,
	input wire logic        tx_empty_request,
	input wire logic        rx_full_request
);
	logic       wr_q;
	logic       stop_sh;
	logic       te_sh;
	logic       re_sh;
	logic [7:0] off_q;
	logic [1:0] port_sh;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Writes land at the end of the data phase; stopped block ignores all but stop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q    <= 1'b0;
			off_q   <= 8'h00;
			stop_sh <= `SPU_STOP_RST;
			te_sh   <= 1'b0;
			re_sh   <= 1'b0;
			port_sh <= 2'b00;
		end else if (hready) begin
			wr_q  <= hsel && htrans[1] && hwrite;
			off_q <= haddr[7:0];
			if (wr_q && off_q == `SPU_OFF_STOP)
				stop_sh <= hwdata[0];
			if (wr_q && !stop_sh && off_q == `SPU_OFF_CTRL) begin
				te_sh <= hwdata[`SPU_CTRL_TE];
				re_sh <= hwdata[`SPU_CTRL_RE];
			end
			if (wr_q && !stop_sh && off_q == `SPU_OFF_PORT)
				port_sh <= hwdata[1:0];
		end
	end
	sequence s_read_taken;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_port_owned;
		!te_sh && !stop_sh;
	endsequence
	ready_always_a: assert property (hreadyout) else $error("Bus stalled");
	resp_okay_a: assert property (!hresp) else $error("Error response");
	stopped_read_a: assert property (s_read_taken ##0 haddr[7:0] != `SPU_OFF_STOP
		|=> !stop_sh || hrdata == 32'h0) else $error("Stopped block returned data");
	port_dir_a: assert property (s_port_owned |=> txd_oe == $past(port_sh[1]))
		else $error("Pin direction not from port");
	port_level_a: assert property (s_port_owned ##0 port_sh[1] |=> txd_out == $past(port_sh[0]))
		else $error("Pin level not from port");
	tx_gate_a: assert property (!te_sh |=> !tx_empty_request) else $error("Tx request while off");
	rx_gate_a: assert property (!re_sh |=> !rx_full_request) else $error("Rx request while off");
	rx_clear_a: assert property (s_read_taken ##0 (haddr[7:0] == `SPU_OFF_RXHOLD && rx_full_request
		&& !stop_sh) |-> ##[1:3] !rx_full_request) else $error("Rx request not dropped");
endmodule
bind spu_serial_port spu_sva u_spu_sva (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.txd_out(txd_out), .txd_oe(txd_oe), .tx_empty_request(tx_empty_request), .rx_full_request(rx_full_request)
);

// ### bench/spu_peer.sv
// Purpose: Remote serial peer on the transmit and receive lines
// Assumes: 8N1 frames, LSB first, bit time given in clock cycles
// Notes: Transmit line is pulled up while the block does not drive it
`timescale 1ns/10ps
module spu_peer (
	// Clock
	input  wire logic hclk,
	// Block pins
	input  wire logic txd_out,
	input  wire logic txd_oe,
	output logic      rxd_in,
	output logic      sck_in
);
	logic line;
	// Pull-up gives mark level on a released pin
	assign line = txd_oe ? txd_out : 1'b1;
	// External clock stands high between clocked bytes
	initial begin
		rxd_in = 1'b1;
		sck_in = 1'b1;
	end
	task automatic set_line(input logic v);
		@(posedge hclk);
		rxd_in <= v;
	endtask
	// Start bit, data LSB first, stop bit
	task automatic send_byte(input logic [7:0] d, input int bc);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge hclk);
			rxd_in <= f[i];
			repeat (bc - 1) @(posedge hclk);
		end
	endtask
	// A missing start bit leaves unknown data, so the caller's compare fails
	task automatic get_byte(output logic [7:0] d, input int bc);
		int n;
		d = 8'hxx;
		for (n = 0; n < 4000 && line !== 1'b0; n++)
			@(posedge hclk);
		if (n < 4000) begin
			repeat (bc / 2) @(posedge hclk);
			for (int i = 0; i < 8; i++) begin
				repeat (bc) @(posedge hclk);
				d[i] = line;
			end
		end
	endtask
	// Clocked byte: falling edge launches a bit, rising edge samples it
	task automatic sync_get(output logic [7:0] d, input int hc);
		// Settle time after the holding register update before any clock edge
		repeat (8) @(posedge hclk);
		for (int i = 0; i < 8; i++) begin
			sck_in <= 1'b0;
			repeat (hc) @(posedge hclk);
			sck_in <= 1'b1;
			d[i] = line;
			repeat (hc) @(posedge hclk);
		end
	endtask
endmodule

// ### bench/spu_serial_port_tb.sv
// Purpose: Self-checking bench of the serial port
// Assumes: Zero-wait bus slave, bit time of BIT cycles
// Notes: Each scenario is its own task
`timescale 1ns/10ps
`include "spu_cfg.svh"
module spu_serial_port_tb;
	import spu_pkg::*;
	localparam int BIT = 8;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic        rxd_in;
	logic        sck_in;
	logic        txd_out;
	logic        txd_oe;
	logic        tx_empty_request;
	logic        rx_full_request;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [7:0]  got;
	int          n_mismatch = 0;
	int          compares = 0;
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	spu_serial_port u_spu_serial_port (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .rxd_in(rxd_in), .sck_in(sck_in), .txd_out(txd_out), .txd_oe(txd_oe),
		.tx_empty_request(tx_empty_request), .rx_full_request(rx_full_request)
	);
	spu_peer u_spu_peer (.hclk(hclk), .txd_out(txd_out), .txd_oe(txd_oe), .rxd_in(rxd_in), .sck_in(sck_in));
	task automatic close_out();
		$display("Compares %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Single word transfer; address phase held until ready, then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		for (n = 0; n == 0 || (hready !== 1'b1 && n < 50); n++)
			@(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		for (n = 0; n == 0 || (hready !== 1'b1 && n < 50); n++)
			@(posedge hclk);
		rd = hrdata;
		if (n >= 50) begin
			n_mismatch++;
			close_out();
		end
	endtask
	// Poll one status bit with a bounded count
	task automatic wait_st(input int b, input logic v);
		int n;
		for (n = 0; n < 400; n++) begin
			bus(1'b0, `SPU_OFF_STATUS, 32'h0);
			if (rd[b] === v)
				break;
		end
		chk("status poll", {31'h0, rd[b]}, {31'h0, v});
	endtask
	task automatic t_stop_init();
		bus(1'b0, `SPU_OFF_STOP, 32'h0);
		chk("stop reset", rd, 32'h1);
		bus(1'b0, `SPU_OFF_STATUS, 32'h0);
		chk("stopped status", rd, 32'h0);
		bus(1'b1, `SPU_OFF_STOP, 32'h0);
		bus(1'b0, `SPU_OFF_STATUS, 32'h0);
		chk("status reset", rd, {24'h0, `SPU_STATUS_RST});
		bus(1'b0, `SPU_OFF_BAUD, 32'h0);
		chk("baud reset", rd, {16'h0, `SPU_BAUD_RST});
		bus(1'b0, 8'h40, 32'h0);
		chk("unmapped", rd, 32'h0);
		bus(1'b1, `SPU_OFF_BAUD, BIT - 1);
		$display("Test stop_init done");
	endtask
	task automatic t_port();
		bus(1'b1, `SPU_OFF_PORT, 32'h2);
		repeat (2) @(posedge hclk);
		chk("port low", {30'h0, txd_oe, txd_out}, 32'h2);
		bus(1'b1, `SPU_OFF_PORT, 32'h3);
		repeat (2) @(posedge hclk);
		chk("mark", {30'h0, txd_oe, txd_out}, 32'h3);
		$display("Test port done");
	endtask
	task automatic t_tx();
		bus(1'b1, `SPU_OFF_CTRL, 32'h1);
		bus(1'b0, `SPU_OFF_STATUS, 32'h0);
		chk("empty before write", {31'h0, rd[`SPU_ST_TX_BUFFER_EMPTY_FLAG]}, 32'h1);
		bus(1'b1, `SPU_OFF_TXHOLD, 32'h11);
		bus(1'b1, `SPU_OFF_TXHOLD, 32'ha5);
		fork
			u_spu_peer.get_byte(got, BIT);
			begin
				bus(1'b1, `SPU_OFF_STATUS, 32'h7f);
				wait_st(`SPU_ST_TX_BUFFER_EMPTY_FLAG, 1'b1);
			end
		join
		chk("sent byte", {24'h0, got}, 32'ha5);
		bus(1'b1, `SPU_OFF_CTRL, 32'h5);
		repeat (2) @(posedge hclk);
		chk("tx request", {31'h0, tx_empty_request}, 32'h1);
		$display("Test tx done");
	endtask
	task automatic t_break_tx();
		bus(1'b1, `SPU_OFF_PORT, 32'h2);
		bus(1'b1, `SPU_OFF_TXHOLD, 32'hff);
		bus(1'b1, `SPU_OFF_STATUS, 32'h7f);
		repeat (3 * BIT) @(posedge hclk);
		bus(1'b1, `SPU_OFF_CTRL, 32'h0);
		repeat (2) @(posedge hclk);
		chk("break out", {30'h0, txd_oe, txd_out}, 32'h2);
		bus(1'b1, `SPU_OFF_PORT, 32'h3);
		$display("Test break_tx done");
	endtask
	task automatic t_rx();
		bus(1'b1, `SPU_OFF_CTRL, 32'h2);
		u_spu_peer.send_byte(8'h3c, BIT);
		wait_st(`SPU_ST_RDRF, 1'b1);
		@(posedge hclk);
		chk("rx request", {31'h0, rx_full_request}, 32'h1);
		bus(1'b0, `SPU_OFF_RXHOLD, 32'h0);
		chk("rx byte", rd, 32'h3c);
		$display("Test rx done");
	endtask
	task automatic t_break_rx();
		u_spu_peer.set_line(1'b0);
		repeat (30 * BIT) @(posedge hclk);
		bus(1'b0, `SPU_OFF_STATUS, 32'h0);
		chk("framing", {31'h0, rd[`SPU_ST_FER]}, 32'h1);
		bus(1'b1, `SPU_OFF_STATUS, 32'hef);
		repeat (30 * BIT) @(posedge hclk);
		bus(1'b0, `SPU_OFF_STATUS, 32'h0);
		chk("framing again", {31'h0, rd[`SPU_ST_FER]}, 32'h1);
		bus(1'b1, `SPU_OFF_CTRL, 32'h0);
		bus(1'b0, `SPU_OFF_STATUS, 32'h0);
		chk("framing kept", {31'h0, rd[`SPU_ST_FER]}, 32'h1);
		u_spu_peer.set_line(1'b1);
		$display("Test break_rx done");
	endtask
	task automatic t_sync();
		bus(1'b1, `SPU_OFF_CTRL, 32'h11);
		bus(1'b1, `SPU_OFF_TXHOLD, 32'h42);
		bus(1'b1, `SPU_OFF_STATUS, 32'h7f);
		repeat (20) @(posedge hclk);
		bus(1'b0, `SPU_OFF_STATUS, 32'h0);
		chk("sync tx held", {31'h0, rd[`SPU_ST_TX_BUFFER_EMPTY_FLAG]}, 32'h0);
		bus(1'b1, `SPU_OFF_STATUS, 32'h05);
		wait_st(`SPU_ST_TX_BUFFER_EMPTY_FLAG, 1'b1);
		u_spu_peer.sync_get(got, BIT);
		chk("sync byte", {24'h0, got}, 32'h42);
		bus(1'b1, `SPU_OFF_CTRL, 32'h0);
		$display("Test sync done");
	endtask
	task automatic t_stop_trans();
		bus(1'b1, `SPU_OFF_CTRL, 32'h2);
		u_spu_peer.send_byte(8'h96, BIT);
		wait_st(`SPU_ST_RDRF, 1'b1);
		bus(1'b1, `SPU_OFF_CTRL, 32'h0);
		bus(1'b1, `SPU_OFF_STOP, 32'h1);
		bus(1'b1, `SPU_OFF_STOP, 32'h0);
		bus(1'b0, `SPU_OFF_STATUS, 32'h0);
		chk("status after stop", rd, {24'h0, `SPU_STATUS_RST});
		bus(1'b0, `SPU_OFF_RXHOLD, 32'h0);
		chk("rx hold after stop", rd, 32'h0);
		$display("Test stop_trans done");
	endtask
	// Hang guard
	initial begin
		repeat (100000) @(posedge hclk);
		n_mismatch++;
		close_out();
	end
	// Main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		hsel <= 1'b1;
		@(posedge hclk);
		t_stop_init();
		t_port();
		t_tx();
		t_break_tx();
		t_rx();
		t_break_rx();
		t_sync();
		t_stop_trans();
		close_out();
	end
endmodule
